// ==== design/sfe_dev.sv ====
// Purpose: Sequencer end: decodes frames, times erase cycles
// Assumes: Link pins are async, synced by two flip-flops
// Notes:   Array is outside; erase_done sets its region to ones

// Notes on behaviour
// RQ1: Page erase leaves every byte at ones
// RQ2: Erase accepted only with latch flag set
// RQ3: Erase frame is code plus three addresses
// RQ4: Any address selects its containing page
// RQ5: Select rising off bit thirty-two discards
// RQ6: Select rise starts the timed erase
// RQ7: Busy flag reads one during cycle
// RQ8: Latch flag cleared during every erase
// RQ9: Protected page is not erased
// RQ10: Erase during a running cycle rejected
// RQ11: Subsector erase refused when sector protected
// RQ12: Reset pin aborts subsector erase
// RQ13: Sector erase sets whole sector ones
// RQ14: Sector erase refused on hardware protection
// RQ15: Bulk and sleep frames are eight bits
// RQ16: Bulk erase refused if anything protected
// RQ17: Reset pin aborts bulk erase
// RQ18: Address bits above array are ignored
// RQ19: Sleep accepted only from standby
// RQ20: Sleep entered after entry delay, ignores erases
// RQ21: Host sends only release while asleep
// RQ22: Comes up awake; sleep during cycle rejected
// RQ23: Asleep, only release command is obeyed
// RQ24: Erase with clear latch silently discarded
module sfe_dev
#(
  parameter int unsigned ADDR_W   = sfe_pkg::ADDR_W_LARGE,
  parameter int unsigned PE_CYC   = sfe_pkg::PAGE_ERASE_CYC,
  parameter int unsigned SSE_CYC  = sfe_pkg::SUB_ERASE_CYC,
  parameter int unsigned SE_CYC   = sfe_pkg::SECT_ERASE_CYC,
  parameter int unsigned BE_CYC   = sfe_pkg::ALL_ERASE_CYC,
  parameter int unsigned DP_CYC   = sfe_pkg::SLEEP_ENTRY_CYC,
  localparam int unsigned NSECT   = 1 << (ADDR_W - sfe_pkg::SECT_SHIFT)
) (
  input  wire logic                core_clk,
  input  wire logic                rstn,
  sfe_link_if.dev                  link,
  input  wire logic [NSECT-1:0]    hw_prot,
  input  wire logic [NSECT-1:0]    sw_prot,
  output logic                     write_busy_flag,
  output logic                     write_latch_flag,
  output logic                     sleeping,
  output logic                     erase_start,
  output sfe_pkg::sfe_erase_type   erase_kind,
  output logic [ADDR_W-1:0]        erase_base,
  output logic                     erase_done,
  output logic                     erase_abort
);
  import sfe_pkg::*;

  typedef enum {S_IDLE, S_ERASE, S_DOZE, S_SLEEP} sfe_dstate_type;

  // Three-address erase code test
  function automatic logic is_erase3(input logic [7:0] c);
    is_erase3 = (c == CMD_PAGE_ERASE) || (c == CMD_SUB_ERASE) || (c == CMD_SECT_ERASE);
  endfunction

  // Pin synchronisers
  logic [1:0]     sel_s_q;          // Select
  logic [1:0]     clk_s_q;          // Serial clock
  logic [1:0]     din_s_q;          // Serial data in
  logic [1:0]     rst_s_q;          // Reset pin
  logic           sel_d1_q;         // Select, one cycle later
  logic           clk_d1_q;         // Serial clock, one cycle later
  // Frame capture
  logic [31:0]    shift_q;          // Bits received, newest in bit 0
  logic [5:0]     cnt_q;            // Clocks seen this frame
  logic           rd_q;             // Status read frame active
  logic [2:0]     rbit_q;           // Status bit being sent
  logic           so_q;             // Serial out level
  logic           so_oe_n_q;        // Serial out enable, active low
  // Sequencer
  sfe_dstate_type state_q;          // Power and cycle state
  logic [31:0]    timer_q;          // Cycle countdown

  assign link.so      = so_q;
  assign link.so_oe_n = so_oe_n_q;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sel_s_q <= 2'b11; clk_s_q <= 2'b00; din_s_q <= 2'b00; rst_s_q <= 2'b11;
      sel_d1_q <= 1'b1; clk_d1_q <= 1'b0;
    end else begin
      sel_s_q  <= {sel_s_q[0], link.select_n};
      clk_s_q  <= {clk_s_q[0], link.sclk};
      din_s_q  <= {din_s_q[0], link.serial_in_line};
      rst_s_q  <= {rst_s_q[0], link.rst_pin_n};
      sel_d1_q <= sel_s_q[1];
      clk_d1_q <= clk_s_q[1];
    end
  end

  // Edges seen in the core domain
  wire sel_n     = sel_s_q[1];
  wire pin_rst   = ~rst_s_q[1];
  wire sclk_rise = clk_s_q[1] & ~clk_d1_q & ~sel_n;
  wire sclk_fall = ~clk_s_q[1] & clk_d1_q & ~sel_n;
  wire sel_rise  = sel_n & ~sel_d1_q;
  wire sel_fall  = ~sel_n & sel_d1_q;

  // Decode of a frame ending at select rise
  wire [7:0]        op8      = shift_q[7:0];
  wire [7:0]        op32     = shift_q[31:24];
  wire              frame8   = (cnt_q == CODE_BITS);
  wire              frame32  = (cnt_q == ADDR_BITS_F);
  wire [ADDR_W-1:0] addr_m   = shift_q[ADDR_W-1:0]; // [RQ18]
  wire [ADDR_W-SECT_SHIFT-1:0] sec = addr_m[ADDR_W-1:SECT_SHIFT];
  wire              any_prot = |(hw_prot | sw_prot);
  wire              prot3    = (op32 == CMD_SECT_ERASE) ? hw_prot[sec]         // [RQ14]
                                                        : (hw_prot[sec] | sw_prot[sec]); // [RQ9] [RQ11]
  wire              go3      = sel_rise & frame32 & is_erase3(op32); // [RQ3] [RQ5]
  wire              go_all   = sel_rise & frame8 & (op8 == CMD_ALL_ERASE);     // [RQ15]
  wire              go_dp    = sel_rise & frame8 & (op8 == CMD_SLEEP);         // [RQ15]
  wire              go_wake  = sel_rise & frame8 & (op8 == CMD_WAKE);
  wire              go_set   = sel_rise & frame8 & (op8 == CMD_LATCH_SET);
  wire              go_clr   = sel_rise & frame8 & (op8 == CMD_LATCH_CLR);
  // Erase only with latch set, unprotected [RQ2] [RQ24] [RQ16]
  wire              start3   = go3 & write_latch_flag & ~prot3;
  wire              startall = go_all & write_latch_flag & ~any_prot;
  wire              rd_go    = sclk_rise & (cnt_q == CODE_BITS - 6'h01)
                               & ({shift_q[6:0], din_s_q[1]} == CMD_STATUS_RD);
  wire [7:0]        status   = {6'h00, write_latch_flag, write_busy_flag};

  // Region base: offset bits dropped [RQ4] [RQ13]
  wire sfe_erase_type kind3 = (op32 == CMD_PAGE_ERASE) ? EK_PAGE
                              : (op32 == CMD_SUB_ERASE) ? EK_SUB : EK_SECT;
  wire [ADDR_W-1:0] base3 = (kind3 == EK_PAGE) ? {addr_m[ADDR_W-1:PAGE_SHIFT], {PAGE_SHIFT{1'b0}}}
                          : (kind3 == EK_SUB)  ? {addr_m[ADDR_W-1:SUB_SHIFT], {SUB_SHIFT{1'b0}}}
                          : {addr_m[ADDR_W-1:SECT_SHIFT], {SECT_SHIFT{1'b0}}};
  wire [31:0]       cyc3  = (kind3 == EK_PAGE) ? PE_CYC : (kind3 == EK_SUB) ? SSE_CYC : SE_CYC;

  // Serial shift and clock count; a reset pulse breaks the frame
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      shift_q <= 32'h0; cnt_q <= 6'h00;
    end else if (pin_rst) begin
      cnt_q <= CNT_BROKEN;
    end else if (sel_fall) begin
      cnt_q <= 6'h00;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[30:0], din_s_q[1]};
      if (cnt_q != CNT_BROKEN) cnt_q <= cnt_q + 6'h01;                         // [RQ5]
    end
  end

  // Status read: bits go out on sclk falls [RQ7]
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rd_q <= 1'b0; rbit_q <= 3'h0; so_q <= 1'b0; so_oe_n_q <= 1'b1;
    end else begin
      so_oe_n_q <= ~(rd_q & ~sel_n);
      if (sel_n || pin_rst) begin
        rd_q <= 1'b0;
      end else if (rd_go && state_q != S_SLEEP && state_q != S_DOZE) begin
        rd_q <= 1'b1; rbit_q <= 3'h0;
      end else if (sclk_fall && rd_q) begin
        so_q   <= status[3'h7 - rbit_q];
        rbit_q <= rbit_q + 3'h1;
      end
    end
  end

  // Command sequencer and cycle timer
  always_ff @(posedge core_clk) begin
    erase_start <= 1'b0;
    erase_done  <= 1'b0;
    erase_abort <= 1'b0;
    if (!rstn) begin
      // Power-up lands in standby [RQ22]
      state_q <= S_IDLE; timer_q <= 32'h0; write_busy_flag <= 1'b0;
      write_latch_flag <= 1'b0; sleeping <= 1'b0; erase_kind <= EK_PAGE;
      erase_base <= '0;
    end else if (pin_rst) begin
      // Reset pin aborts any cycle [RQ12] [RQ17]
      if (state_q == S_ERASE) erase_abort <= 1'b1;
      state_q <= S_IDLE; write_busy_flag <= 1'b0; write_latch_flag <= 1'b0;
      sleeping <= 1'b0; timer_q <= 32'h0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start3) begin
            // Latch cleared as the cycle starts [RQ6] [RQ8] [RQ1]
            state_q <= S_ERASE; write_busy_flag <= 1'b1; write_latch_flag <= 1'b0;
            timer_q <= cyc3; erase_kind <= kind3; erase_base <= base3; erase_start <= 1'b1;
          end else if (startall) begin
            state_q <= S_ERASE; write_busy_flag <= 1'b1; write_latch_flag <= 1'b0;   // [RQ6] [RQ8]
            timer_q <= BE_CYC; erase_kind <= EK_ALL; erase_base <= '0; erase_start <= 1'b1;
          end else if (go_dp) begin
            // Standby only; entry waits out the delay [RQ19] [RQ20]
            state_q <= S_DOZE; timer_q <= DP_CYC;
          end else if (go_set) begin
            write_latch_flag <= 1'b1;
          end else if (go_clr) begin
            write_latch_flag <= 1'b0;
          end
        end
        S_ERASE: begin
          // Every frame but a status read ignored until the cycle ends [RQ10] [RQ22]
          if (timer_q <= 32'h1) begin
            state_q <= S_IDLE; write_busy_flag <= 1'b0; erase_done <= 1'b1;     // [RQ7]
          end else begin
            timer_q <= timer_q - 32'h1;
          end
        end
        S_DOZE: begin
          if (timer_q <= 32'h1) begin
            state_q <= S_SLEEP; sleeping <= 1'b1;                               // [RQ20]
          end else begin
            timer_q <= timer_q - 32'h1;
          end
        end
        S_SLEEP: begin
          // Only the release frame is obeyed [RQ23] [RQ20]
          if (go_wake) begin
            state_q <= S_IDLE; sleeping <= 1'b0;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== inc/sfe_pkg.sv ====
// Purpose: Shared constants and types
// Assumes: core_clk at 250 MHz
// Notes:   Times convert to cycles here
package sfe_pkg;
  // Core clock rate
  localparam int unsigned CORE_CLK_MHZ = 250;
  // Command codes
  localparam logic [7:0] CMD_LATCH_SET  = 8'h06;
  localparam logic [7:0] CMD_LATCH_CLR  = 8'h04;
  localparam logic [7:0] CMD_STATUS_RD  = 8'h05;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'hdb;
  localparam logic [7:0] CMD_SUB_ERASE  = 8'h20;
  localparam logic [7:0] CMD_SECT_ERASE = 8'hd8;
  localparam logic [7:0] CMD_ALL_ERASE  = 8'hc7;
  localparam logic [7:0] CMD_SLEEP      = 8'hb9;
  localparam logic [7:0] CMD_WAKE       = 8'hab;
  // Frame lengths in serial clocks
  localparam logic [5:0] CODE_BITS   = 6'h08;
  localparam logic [5:0] STATUS_BITS = 6'h10;
  localparam logic [5:0] ADDR_BITS_F = 6'h20;
  localparam logic [5:0] CNT_BROKEN  = 6'h3f;
  // Status byte field positions
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_LATCH_BIT = 1;
  // Address widths and region shifts
  localparam int unsigned ADDR_W_LARGE = 18;
  localparam int unsigned ADDR_W_SMALL = 17;
  localparam int unsigned PAGE_SHIFT   = 8;
  localparam int unsigned SUB_SHIFT    = 12;
  localparam int unsigned SECT_SHIFT   = 16;
  // Self-timed durations
  localparam int unsigned PAGE_ERASE_TIME_US  = 10000;
  localparam int unsigned SUB_ERASE_TIME_US   = 150000;
  localparam int unsigned SECT_ERASE_TIME_US  = 1000000;
  localparam int unsigned ALL_ERASE_TIME_US   = 2000000;
  localparam int unsigned SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int unsigned RESET_RECOVERY_DELAY_NS = 30000;
  localparam int unsigned RESET_PULSE_NS      = 100;
  localparam int unsigned LINK_HALF_NS        = 80;
  // Cycle counts
  localparam int unsigned PAGE_ERASE_CYC = PAGE_ERASE_TIME_US * CORE_CLK_MHZ;
  localparam int unsigned SUB_ERASE_CYC  = SUB_ERASE_TIME_US * CORE_CLK_MHZ;
  localparam int unsigned SECT_ERASE_CYC = SECT_ERASE_TIME_US * CORE_CLK_MHZ;
  localparam int unsigned ALL_ERASE_CYC  = ALL_ERASE_TIME_US * CORE_CLK_MHZ;
  localparam int unsigned SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned RECOVERY_CYC   = (RESET_RECOVERY_DELAY_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned LINK_HALF_CYC  = (LINK_HALF_NS * CORE_CLK_MHZ) / 1000;
  // Kind of erase under way
  typedef enum logic [1:0] {EK_PAGE, EK_SUB, EK_SECT, EK_ALL} sfe_erase_type;
endpackage

// ==== inc/sfe_link_if.sv ====
// Purpose: Serial link, host to sequencer
// Assumes: Released so reads high
// Notes:   The output enable is active low
interface sfe_link_if;
  logic select_n;       // Device select, low while framed
  logic sclk;           // Serial clock from the host
  logic serial_in_line; // Host to device data
  logic rst_pin_n;      // Hardware reset pin, active low
  logic so;             // Device data out
  logic so_oe_n;        // Device drives so while low
  logic so_line;        // Resolved wire level

  // Released wire reads as pulled high
  assign so_line = so_oe_n ? 1'b1 : so;

  modport dev  (input select_n, input sclk, input serial_in_line, input rst_pin_n,
                output so, output so_oe_n);
  modport host (output select_n, output sclk, output serial_in_line, output rst_pin_n,
                input so_line);
endinterface

// ==== design/sfe_host.sv ====
// Purpose: Host end: frames commands, drives reset pin
// Assumes: sclk divided from core_clk; data moves while sclk low
// Notes:   Each erase is preceded by a latch-set frame
module sfe_host
#(
  parameter int unsigned HALF_CYC  = sfe_pkg::LINK_HALF_CYC,
  parameter int unsigned RECOV_CYC = sfe_pkg::RECOVERY_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  sfe_link_if.host         link,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [23:0] cmd_addr,
  output logic             cmd_ready,
  input  wire logic        reset_req,
  output logic [7:0]       status_byte,
  output logic             status_valid,
  output logic             asleep
);
  import sfe_pkg::*;

  typedef enum {H_IDLE, H_LOW, H_HIGH, H_END, H_GAP, H_RST, H_RECOV} sfe_hstate_type;

  // Frame length for a command code
  function automatic logic [5:0] frame_len(input logic [7:0] c);
    if (c == CMD_PAGE_ERASE || c == CMD_SUB_ERASE || c == CMD_SECT_ERASE) frame_len = ADDR_BITS_F;
    else if (c == CMD_STATUS_RD) frame_len = STATUS_BITS;
    else frame_len = CODE_BITS;
  endfunction

  sfe_hstate_type state_q;          // Sequencer state
  logic [31:0]    tx_q;             // Bits still to send, MSB first
  logic [15:0]    rx_q;             // Bits sampled from so
  logic [5:0]     len_q;            // Clocks in this frame
  logic [5:0]     bits_q;           // Clocks sent so far
  logic [31:0]    div_q;            // Phase and wait counter
  logic [7:0]     code_q;           // Code of the current frame
  logic [7:0]     pend_code_q;      // Erase waiting behind latch-set
  logic [23:0]    pend_addr_q;      // Its address
  logic           pend_q;           // An erase is queued
  logic [1:0]     so_s_q;           // Two-stage sync of so
  logic           sel_n_q, sclk_q, sdi_q, rstp_n_q;

  wire        div_end   = (div_q == HALF_CYC - 1);
  wire        div_wrap  = div_end && state_q != H_RST && state_q != H_RECOV; // Long waits run on
  wire [5:0]  bits_nx   = bits_q + 6'h01;
  wire        is_erase  = (frame_len(cmd_code) == ADDR_BITS_F) || (cmd_code == CMD_ALL_ERASE);
  wire        accept    = cmd_valid & cmd_ready;
  wire        drop      = asleep & (cmd_code != CMD_WAKE);    // [RQ21]

  assign link.select_n       = sel_n_q;
  assign link.sclk           = sclk_q;
  assign link.serial_in_line = sdi_q;
  assign link.rst_pin_n      = rstp_n_q;

  // Sync the device output before sampling
  always_ff @(posedge core_clk) begin
    if (!rstn) so_s_q <= 2'b11;
    else so_s_q <= {so_s_q[0], link.so_line};
  end

  // Frame sequencer
  always_ff @(posedge core_clk) begin
    status_valid <= 1'b0;
    div_q        <= div_wrap ? 32'h0 : div_q + 32'h1;
    if (!rstn) begin
      state_q <= H_IDLE; sel_n_q <= 1'b1; sclk_q <= 1'b0; sdi_q <= 1'b0; rstp_n_q <= 1'b1;
      tx_q <= 32'h0; rx_q <= 16'h0; len_q <= 6'h0; bits_q <= 6'h0; div_q <= 32'h0;
      code_q <= 8'h0; pend_q <= 1'b0; pend_code_q <= 8'h0; pend_addr_q <= 24'h0;
      cmd_ready <= 1'b1; status_byte <= 8'h0; asleep <= 1'b0;
    end else begin
      case (state_q)
        H_IDLE: begin
          div_q <= 32'h0;
          if (reset_req) begin
            // Pulse the pin, then recover
            state_q <= H_RST; rstp_n_q <= 1'b0; cmd_ready <= 1'b0;
          end else if (accept && !drop) begin
            cmd_ready <= 1'b0; state_q <= H_LOW; sel_n_q <= 1'b0; bits_q <= 6'h0;
            if (is_erase) begin
              // Latch-set first, the erase follows [RQ2]
              pend_q <= 1'b1; pend_code_q <= cmd_code; pend_addr_q <= cmd_addr;
              code_q <= CMD_LATCH_SET; len_q <= CODE_BITS;
              sdi_q <= CMD_LATCH_SET[7]; tx_q <= {CMD_LATCH_SET[6:0], 25'h0};
            end else begin
              code_q <= cmd_code; len_q <= frame_len(cmd_code);
              sdi_q <= cmd_code[7]; tx_q <= {cmd_code[6:0], cmd_addr, 1'b0};
            end
          end
        end
        H_LOW: if (div_end) begin
          sclk_q <= 1'b1; state_q <= H_HIGH;
        end
        H_HIGH: if (div_end) begin
          // Sample at the end of the high phase, then fall
          rx_q <= {rx_q[14:0], so_s_q[1]}; sclk_q <= 1'b0; bits_q <= bits_nx;
          if (bits_nx == len_q) state_q <= H_END;         // [RQ3] [RQ15]
          else begin
            sdi_q <= tx_q[31]; tx_q <= {tx_q[30:0], 1'b0}; state_q <= H_LOW;
          end
        end
        H_END: if (div_end) begin
          // Raise select a half period after the last clock falls [RQ5]
          sel_n_q <= 1'b1; state_q <= H_GAP;
          if (code_q == CMD_SLEEP) asleep <= 1'b1;
          if (code_q == CMD_WAKE) asleep <= 1'b0;
          if (code_q == CMD_STATUS_RD) begin
            status_byte <= rx_q[7:0]; status_valid <= 1'b1;
          end
        end
        H_GAP: if (div_end) begin
          if (pend_q) begin
            pend_q <= 1'b0; code_q <= pend_code_q; len_q <= frame_len(pend_code_q);
            sdi_q <= pend_code_q[7]; tx_q <= {pend_code_q[6:0], pend_addr_q, 1'b0};
            bits_q <= 6'h0; sel_n_q <= 1'b0; state_q <= H_LOW;
          end else begin
            state_q <= H_IDLE; cmd_ready <= 1'b1;
          end
        end
        H_RST: if (div_q == RESET_PULSE_CYC - 1) begin
          rstp_n_q <= 1'b1; div_q <= 32'h0; state_q <= H_RECOV; asleep <= 1'b0;
        end
        H_RECOV: if (div_q == RECOV_CYC - 1) begin
          // Select stays high for the recovery delay [RQ12] [RQ17]
          state_q <= H_IDLE; cmd_ready <= 1'b1;
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end
endmodule

// ==== tb/sfe_monitor.sv ====
// Purpose: Checks on link pins and device flags
// Assumes: Erase counts near 2000, sleep entry 10
// Notes:   Watches registered device outputs
module sfe_monitor (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic select_n,
  input wire logic rst_pin_n,
  input wire logic so_oe_n,
  input wire logic write_busy_flag,
  input wire logic write_latch_flag,
  input wire logic sleeping,
  input wire logic erase_start,
  input wire logic erase_done,
  input wire logic erase_abort
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Reset pin hit during a cycle, then abort
  sequence s_pin_hit; $fell(rst_pin_n) ##0 write_busy_flag; endsequence
  sequence s_abort_seen; ##[1:5] erase_abort; endsequence
  property p_start_idle; erase_start |-> select_n && !sleeping; endproperty
  a_start_idle: assert property (p_start_idle) else $error("bad start");
  property p_busy_on; erase_start |-> ##[0:1] write_busy_flag; endproperty
  a_busy_on: assert property (p_busy_on) else $error("no busy");
  property p_busy_end; $fell(write_busy_flag) |-> erase_done || erase_abort; endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy fell early");
  property p_latch_clr; erase_start |-> ##[0:1] !write_latch_flag; endproperty
  a_latch_clr: assert property (p_latch_clr) else $error("latch set");
  property p_abort; s_pin_hit |-> s_abort_seen; endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_abort_clr; erase_abort |-> ##[0:1] (!write_busy_flag && !write_latch_flag); endproperty
  a_abort_clr: assert property (p_abort_clr) else $error("flags kept");
  property p_so_rel; select_n [*8] |-> so_oe_n; endproperty
  a_so_rel: assert property (p_so_rel) else $error("so driven");
  property p_sleep_idle; sleeping |-> !write_busy_flag; endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("busy asleep");
  property p_sleep_dly; $rose(sleeping) |-> $past(select_n, 8); endproperty
  a_sleep_dly: assert property (p_sleep_dly) else $error("sleep early");
  property p_done_once; erase_done |=> !erase_done && !write_busy_flag; endproperty
  a_done_once: assert property (p_done_once) else $error("done held");
endmodule

// ==== tb/serial_flash_erase_and_sleep_control_tb.sv ====
// Purpose: Host and sequencer, plus a raw-frame sequencer
// Assumes: Short erase counts; link half period 20 cycles
// Notes:   Bases expected from the address masked to 18 bits
module serial_flash_erase_and_sleep_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sfe_pkg::*;
  localparam int HALF = 20, RC = 20, PE = 2000, SSE = 2100, SE = 2200, BE = 2300, DP = 10;
  logic          core_clk = 1'b0;
  logic          rstn = 1'b0;
  logic          cmd_valid = 1'b0;
  logic [7:0]    cmd_code = 8'h00;
  logic [23:0]   cmd_addr = 24'h000000;
  logic          reset_req = 1'b0;
  logic [3:0]    hw_prot = 4'h0;
  logic [3:0]    sw_prot = 4'h0;
  logic          cmd_ready, status_valid, asleep, busy, latch, sleeping, e_start, e_done, e_abort;
  logic          busy2, latch2, sleep2, e_start2;
  logic [7:0]    status_byte, st_q;
  logic [17:0]   ebase, base;
  sfe_erase_type ekind, kind;
  int            n_st = 0, n_dn = 0, n_ab = 0, n_st2 = 0, miscompares = 0, n_compared = 0;
  sfe_link_if    link ();
  sfe_link_if    link2 ();
  always #2 core_clk = ~core_clk;
  sfe_host #(.HALF_CYC(HALF), .RECOV_CYC(RC)) sfe_host_inst (.core_clk(core_clk), .rstn(rstn), .link(link),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .reset_req(reset_req),
    .status_byte(status_byte), .status_valid(status_valid), .asleep(asleep));
  sfe_dev #(.PE_CYC(PE), .SSE_CYC(SSE), .SE_CYC(SE), .BE_CYC(BE), .DP_CYC(DP)) sfe_dev_inst (
    .core_clk(core_clk), .rstn(rstn), .link(link), .hw_prot(hw_prot), .sw_prot(sw_prot), .write_busy_flag(busy),
    .write_latch_flag(latch), .sleeping(sleeping), .erase_start(e_start), .erase_kind(ekind), .erase_base(ebase),
    .erase_done(e_done), .erase_abort(e_abort));
  sfe_dev #(.PE_CYC(PE), .SSE_CYC(SSE), .SE_CYC(SE), .BE_CYC(BE), .DP_CYC(DP)) sfe_dev_inst2 (
    .core_clk(core_clk), .rstn(rstn), .link(link2), .hw_prot(hw_prot), .sw_prot(sw_prot), .write_busy_flag(busy2),
    .write_latch_flag(latch2), .sleeping(sleep2), .erase_start(e_start2), .erase_kind(), .erase_base(),
    .erase_done(), .erase_abort());
  sfe_monitor sfe_monitor_inst (.core_clk(core_clk), .rstn(rstn), .select_n(link.select_n),
    .rst_pin_n(link.rst_pin_n), .so_oe_n(link.so_oe_n), .write_busy_flag(busy), .write_latch_flag(latch),
    .sleeping(sleeping), .erase_start(e_start), .erase_done(e_done), .erase_abort(e_abort));
  // Event counters and captures
  always @(posedge core_clk) begin
    if (e_start) begin
      n_st++;
      kind = ekind;
      base = ebase;
    end
    if (e_done) n_dn++;
    if (e_abort) n_ab++;
    if (e_start2) n_st2++;
    if (status_valid) st_q = status_byte;
  end
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic wait_rdy();
    for (int i = 0; i < 20000 && cmd_ready !== 1'b1; i++) @(negedge core_clk);
    chk(1, cmd_ready);
  endtask
  // One host request, back when idle
  task automatic issue(input logic [7:0] c, input logic [23:0] a);
    wait_rdy();
    cmd_code = c;
    cmd_addr = a;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    @(negedge core_clk);
    wait_rdy();
  endtask
  task automatic rd_st(input logic [7:0] exp);
    issue(CMD_STATUS_RD, 24'h000000);
    chk(exp, st_q);
  endtask
  task automatic wait_done(input int t);
    for (int i = 0; i < 4000 && n_dn < t; i++) @(negedge core_clk);
    chk(t, n_dn);
  endtask
  // Raw n-bit mode-0 frame on the second link
  task automatic raw(input logic [31:0] v, input int n);
    link2.select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      link2.serial_in_line = v[i];
      repeat (HALF) @(negedge core_clk);
      link2.sclk = 1'b1;
      repeat (HALF) @(negedge core_clk);
      link2.sclk = 1'b0;
    end
    repeat (HALF) @(negedge core_clk);
    link2.select_n = 1'b1;
    link2.serial_in_line = ~link2.serial_in_line;
    repeat (2 * HALF) @(negedge core_clk);
  endtask
  task automatic t_kinds();
    logic [7:0] c [4] = '{CMD_PAGE_ERASE, CMD_SUB_ERASE, CMD_SECT_ERASE, CMD_ALL_ERASE};
    int         sh [4] = '{PAGE_SHIFT, SUB_SHIFT, SECT_SHIFT, 18};
    for (int k = 0; k < 4; k++) begin
      issue(c[k], 24'hfe5a5a);
      chk(k + 1, n_st);
      chk(k, kind);
      chk((18'h25a5a >> sh[k]) << sh[k], base);
      rd_st(8'h01);
      wait_done(k + 1);
      rd_st(8'h00);
    end
    $display("kinds done");
  endtask
  task automatic t_prot();
    logic [7:0]  c [6] = '{CMD_PAGE_ERASE, CMD_PAGE_ERASE, CMD_SECT_ERASE, CMD_SECT_ERASE, CMD_SUB_ERASE, CMD_ALL_ERASE};
    logic [23:0] a [6] = '{24'h010100, 24'h020100, 24'h01ff00, 24'h020000, 24'h02f000, 24'h000000};
    int          go [6] = '{0, 0, 0, 1, 0, 0};
    hw_prot = 4'h2;
    sw_prot = 4'h4;
    for (int k = 0; k < 6; k++) begin
      int m;
      m = n_st;
      issue(c[k], a[k]);
      chk(m + go[k], n_st);
      if (go[k] != 0) wait_done(n_dn + 1);
    end
    hw_prot = 4'h0;
    sw_prot = 4'h0;
    $display("prot done");
  endtask
  task automatic t_busy();
    int m, d;
    d = n_dn;
    issue(CMD_SECT_ERASE, 24'h030000);
    m = n_st;
    issue(CMD_PAGE_ERASE, 24'h000100);
    issue(CMD_SLEEP, 24'h000000);
    chk(m, n_st);
    chk(0, sleeping);
    issue(CMD_WAKE, 24'h000000);
    wait_done(d + 1);
    $display("busy done");
  endtask
  task automatic t_abort();
    logic [7:0] c [2] = '{CMD_SUB_ERASE, CMD_ALL_ERASE};
    for (int k = 0; k < 2; k++) begin
      int m;
      m = n_ab;
      issue(c[k], 24'h000000);
      reset_req = 1'b1;
      @(negedge core_clk);
      reset_req = 1'b0;
      @(negedge core_clk);
      wait_rdy();
      chk(m + 1, n_ab);
      rd_st(8'h00);
    end
    $display("abort done");
  endtask
  task automatic t_sleep();
    int m;
    m = n_st;
    issue(CMD_SLEEP, 24'h000000);
    repeat (2 * DP) @(negedge core_clk);
    chk(1, sleeping);
    chk(1, asleep);
    issue(CMD_PAGE_ERASE, 24'h000000);
    chk(m, n_st);
    issue(CMD_WAKE, 24'h000000);
    chk(0, sleeping);
    $display("sleep done");
  endtask
  task automatic t_raw();
    raw(32'hdb012345, 32);
    chk(0, n_st2);
    raw(CMD_LATCH_SET, 8);
    raw(32'hdb012345 >> 1, 31);
    chk(0, n_st2);
    raw({CMD_ALL_ERASE, 1'b0}, 9);
    chk(0, n_st2);
    chk(1, latch2);
    raw(CMD_ALL_ERASE, 8);
    chk(1, n_st2);
    for (int i = 0; i < 4000 && busy2; i++) @(negedge core_clk);
    raw(CMD_SLEEP, 8);
    chk(1, sleep2);
    raw(CMD_LATCH_SET, 8);
    raw(CMD_ALL_ERASE, 8);
    chk(1, n_st2);
    raw(CMD_WAKE, 8);
    chk(0, sleep2);
    $display("raw done");
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    link2.select_n = 1'b1;
    link2.sclk = 1'b0;
    link2.serial_in_line = 1'b0;
    link2.rst_pin_n = 1'b1;
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    chk(3'b000, {busy, latch, sleeping});
    t_kinds();
    t_prot();
    t_busy();
    t_abort();
    t_sleep();
    t_raw();
    conclude();
  end
  // Watchdog past the expected run
  initial begin
    repeat (90000) @(posedge core_clk);
    miscompares++;
    conclude();
  end
endmodule
